// ---- inc/tws_consts.svh ----
// Constants of the two-wire slave transmitter: register offsets, bit positions,
// reset values and status codes.
// Assumes byte addresses on a 32-bit APB bus, one aligned word per register.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define TWS_OFF_CONTROL    8'h00
`define TWS_OFF_STATUS     8'h04
`define TWS_OFF_DATA       8'h08
`define TWS_OFF_OWN_ADDR   8'h0C

// ==========================================================================
// Bit positions in bus_control
`define TWS_CTL_IRQ_FLAG   7
`define TWS_CTL_ACK_EN     6
`define TWS_CTL_START_REQ  5
`define TWS_CTL_STOP_REQ   4
`define TWS_CTL_WCOL       3
`define TWS_CTL_IFACE_EN   2
`define TWS_CTL_IRQ_EN     0

// ==========================================================================
// Reset values
`define TWS_RST_CONTROL    8'h00
`define TWS_RST_OWN_ADDR   8'hFE
`define TWS_RST_DATA       8'hFF
`define TWS_RST_PRESC      2'h0

// ==========================================================================
// Status codes, prescaler bits zero
`define TWS_ST_OWN_READ    8'hA8
`define TWS_ST_ARB_READ    8'hB0
`define TWS_ST_DATA_ACK    8'hB8
`define TWS_ST_DATA_NACK   8'hC0
`define TWS_ST_LAST_ACK    8'hC8
`define TWS_ST_NO_INFO     8'hF8
`define TWS_BCAST_ADDR     7'h00
`define TWS_BITS_PER_BYTE  4'h8

`endif

// ---- inc/tws_pkg.sv ----
// Types shared by the two-wire slave transmitter files.
// Assumes nothing beyond a SystemVerilog compiler.
package tws_pkg;

  // ========================================================================
  // Pin carriers
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } tws_pins_out_t;

  // ========================================================================
  // Bus events seen on the filtered lines
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } tws_events_t;

  // ========================================================================
  // Slave engine states
  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_ADDR,
    TWS_AACK,
    TWS_HOLD,
    TWS_DATA,
    TWS_DACK,
    TWS_IGNORE
  } tws_state_t;

endpackage : tws_pkg

// ---- verilog/tws_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes the inputs are unrelated to clk; output moves when stages 2 and 3 agree.
module tws_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  initial begin
    if (W < 1) $error("tws_sync: W must be at least 1");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q  <= '1;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) q[i] <= s3[i];
      end
    end
  end

endmodule : tws_sync

// ---- verilog/tws_cond_det.sv ----
// Edge and START/STOP detector on filtered clock and data lines.
// Assumes both lines are already synchronous to clk; events are one-cycle pulses.
module tws_cond_det
  import tws_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Filtered lines
  input  tws_pkg::tws_pins_in_t lines,
  // Events
  output tws_pkg::tws_events_t  ev
);

  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= lines.scl;
      sda_q <= lines.sda;
    end
  end

  always_comb begin
    ev.scl_rise = lines.scl & ~scl_q;
    ev.scl_fall = ~lines.scl & scl_q;
    ev.start    = lines.scl & scl_q & sda_q & ~lines.sda;
    ev.stop     = lines.scl & scl_q & ~sda_q & lines.sda;
  end

endmodule : tws_cond_det

// ---- verilog/tws_slave_tx.sv ----
// Two-wire slave transmitter with APB register access.
// Assumes pclk well above the bus clock; pins are open drain, resolved outside.
//
// How it works
// R1: Answer own seven-bit address; answer broadcast address only when its enable bit set.
// R2: Software enables interface and acknowledge, writes start and stop requests zero.
// R3: After a match, read direction enters transmit; write direction is not served.
// R4: Own address plus direction received sets the flag with a valid status.
// R5: Own read address acknowledged reports A8; software loads byte, picks last.
// R6: Addressed for reading after lost arbitration reports B0, same choices.
// R7: Byte sent and acknowledged reports B8; software loads next byte.
// R8: Byte sent without acknowledge reports C0, then not-addressed state.
// R9: Last byte acknowledged anyway reports C8, then not-addressed state.
// R10: After C0 or C8, recognition follows acknowledge enable and broadcast enable.
// R11: Start request written with C0 or C8 response starts once bus free.
// R12: Software clears the flag by writing one and writes stop request zero.
// R13: Clearing acknowledge enable mid-transfer sends one last byte, then C0 or C8.
// R14: After the last byte, further master clocks see a released data line.
// R15: With acknowledge enable zero, own address is not answered; monitoring continues.
// R16: In sleep, with acknowledge enable set, address match still works.
// R17: A match in sleep wakes the processor; clock held low until flag cleared.
// R18: Data register content after wake-up is undefined; only software writes it.
// R19: Software masks prescaler bits before comparing status codes.
// R20: Status reads F8 whenever the flag is clear.
// R21: Bytes go out MSB first, data changing only while the clock is low; each byte's MSB changes on the edge that releases SCL.
//
// Decided for this implementation: the address map and the APB register port.
`include "tws_consts.svh"
module tws_slave_tx
  import tws_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Two-wire pins
  input  tws_pkg::tws_pins_in_t  pins_in,
  output tws_pkg::tws_pins_out_t pins_out,
  // Master-side links and power
  input  wire logic              arb_lost,
  input  wire logic              sleep_mode,
  output logic                   wake,
  output logic                   gen_start
);
  import tws_pkg::*;

  initial begin
    if (ADDR_W < 4) $error("tws_slave_tx: ADDR_W must be at least 4");
  end

  // ========================================================================
  // Line capture
  tws_pins_in_t lines;
  tws_events_t  ev;

  tws_sync #(.W(2)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({pins_in.scl, pins_in.sda}),
    .q     ({lines.scl, lines.sda})
  );

  tws_cond_det u_det (
    .clk   (pclk),
    .rst_n (presetn),
    .lines (lines),
    .ev    (ev)
  );

  // ========================================================================
  // Registers
  logic [7:0]  control;
  logic [7:0]  own_addr;
  logic [7:0]  data_reg;
  logic [7:0]  status_code;
  logic [1:0]  prescaler;
  tws_state_t  state;
  logic [7:0]  shreg;
  logic [3:0]  cnt;
  logic        sda_drv;
  logic        acked;
  logic        last;
  logic        leaving;
  logic        arb_flag;
  logic        bus_free;
  logic        irq_set;
  logic [7:0]  next_code;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        addr_hit;
  logic [7:0]  status_read;

  localparam logic [7:0] NO_INFO = `TWS_ST_NO_INFO;

  wire ack_en = control[`TWS_CTL_ACK_EN];
  wire irq_flag = control[`TWS_CTL_IRQ_FLAG];
  wire iface_en = control[`TWS_CTL_IFACE_EN];

  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == ADDR_W'(`TWS_OFF_CONTROL)) | (paddr == ADDR_W'(`TWS_OFF_STATUS)) |
                  (paddr == ADDR_W'(`TWS_OFF_DATA))    | (paddr == ADDR_W'(`TWS_OFF_OWN_ADDR));
  assign pslverr = psel & penable & ~mapped;

  // No status while the flag is clear
  assign status_read = irq_flag ? {status_code[7:3], 1'b0, prescaler}
                                : {NO_INFO[7:3], 1'b0, prescaler};          // [R20]

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == ADDR_W'(`TWS_OFF_CONTROL))  prdata[7:0] = control;
    if (paddr == ADDR_W'(`TWS_OFF_STATUS))   prdata[7:0] = status_read;
    if (paddr == ADDR_W'(`TWS_OFF_DATA))     prdata[7:0] = data_reg;
    if (paddr == ADDR_W'(`TWS_OFF_OWN_ADDR)) prdata[7:0] = own_addr;
  end

  // Own address, or broadcast when enabled, and only while acknowledging
  assign addr_hit = iface_en & ack_en &                                       // [R15] [R16]
                    ((shreg[7:1] == own_addr[7:1]) |
                     ((shreg[7:1] == `TWS_BCAST_ADDR) & own_addr[0]));        // [R1] [R10]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr  <= `TWS_RST_OWN_ADDR;
      prescaler <= `TWS_RST_PRESC;
    end else if (wr) begin
      if (paddr == ADDR_W'(`TWS_OFF_OWN_ADDR)) own_addr <= pwdata[7:0];
      if (paddr == ADDR_W'(`TWS_OFF_STATUS))   prescaler <= pwdata[1:0];
    end
  end

  // Data register changes only by software; bus traffic never lands here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= `TWS_RST_DATA;
    end else if (wr && paddr == ADDR_W'(`TWS_OFF_DATA) && irq_flag) begin
      data_reg <= pwdata[7:0];                                                // [R18]
    end
  end

  // Control: hardware set of the flag wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= `TWS_RST_CONTROL;
    end else begin
      if (wr && paddr == ADDR_W'(`TWS_OFF_CONTROL)) begin
        control[`TWS_CTL_ACK_EN]    <= pwdata[`TWS_CTL_ACK_EN];
        control[`TWS_CTL_START_REQ] <= pwdata[`TWS_CTL_START_REQ];
        control[`TWS_CTL_STOP_REQ]  <= pwdata[`TWS_CTL_STOP_REQ];
        control[`TWS_CTL_IFACE_EN]  <= pwdata[`TWS_CTL_IFACE_EN];
        control[`TWS_CTL_IRQ_EN]    <= pwdata[`TWS_CTL_IRQ_EN];
        if (pwdata[`TWS_CTL_IRQ_FLAG]) control[`TWS_CTL_IRQ_FLAG] <= 1'b0;
      end
      if (wr && paddr == ADDR_W'(`TWS_OFF_DATA)) begin
        control[`TWS_CTL_WCOL] <= ~irq_flag;
      end
      if (gen_start) control[`TWS_CTL_START_REQ] <= 1'b0;
      if (irq_set) control[`TWS_CTL_IRQ_FLAG] <= 1'b1;                        // [R4]
      if (!iface_en) control[`TWS_CTL_IRQ_FLAG] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_code <= `TWS_ST_NO_INFO;
    end else if (irq_set) begin
      status_code <= next_code;
    end
  end

  // ========================================================================
  // Bus bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_free <= 1'b1;
      arb_flag <= 1'b0;
    end else begin
      if (ev.start) bus_free <= 1'b0;
      else if (ev.stop) bus_free <= 1'b1;
      if (arb_lost) arb_flag <= 1'b1;
      else if (ev.stop || (state == TWS_AACK && ev.scl_fall)) arb_flag <= 1'b0;
    end
  end

  // Start once the bus is free and nothing is addressed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_start <= 1'b0;
    end else begin
      gen_start <= control[`TWS_CTL_START_REQ] & bus_free & ~irq_flag & ~gen_start &
                   (state == TWS_IDLE || state == TWS_IGNORE);                // [R11]
    end
  end

  // ========================================================================
  // Slave engine
  always_comb begin
    irq_set   = 1'b0;
    next_code = `TWS_ST_NO_INFO;
    if (state == TWS_AACK && ev.scl_fall) begin
      irq_set   = 1'b1;
      next_code = arb_flag ? `TWS_ST_ARB_READ : `TWS_ST_OWN_READ;             // [R5] [R6]
    end else if (state == TWS_DACK && ev.scl_fall) begin
      irq_set   = 1'b1;
      if (!acked) next_code = `TWS_ST_DATA_NACK;                              // [R8]
      else if (last) next_code = `TWS_ST_LAST_ACK;                            // [R9] [R13]
      else next_code = `TWS_ST_DATA_ACK;                                      // [R7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= TWS_IDLE;
      shreg   <= 8'h00;
      cnt     <= 4'h0;
      sda_drv <= 1'b0;
      acked   <= 1'b0;
      last    <= 1'b0;
      leaving <= 1'b0;
      wake    <= 1'b0;
    end else begin
      wake <= 1'b0;
      if (!iface_en || ev.stop) begin
        state   <= TWS_IDLE;
        sda_drv <= 1'b0;
      end else if (ev.start) begin
        state   <= TWS_ADDR;
        cnt     <= 4'h0;
        sda_drv <= 1'b0;
      end else begin
        unique case (state)
          TWS_IDLE, TWS_IGNORE: sda_drv <= 1'b0;                              // [R14]
          TWS_ADDR: begin
            if (ev.scl_rise) begin
              shreg <= {shreg[6:0], lines.sda};
              cnt   <= cnt + 4'h1;
            end else if (ev.scl_fall && cnt == `TWS_BITS_PER_BYTE) begin
              if (addr_hit && shreg[0]) begin                                 // [R3]
                sda_drv <= 1'b1;
                state   <= TWS_AACK;
                wake    <= sleep_mode;                                        // [R17]
              end else begin
                state <= TWS_IGNORE;
              end
            end
          end
          TWS_AACK: begin
            if (ev.scl_fall) begin
              sda_drv <= 1'b0;
              leaving <= 1'b0;
              state   <= TWS_HOLD;
            end
          end
          TWS_HOLD: begin
            if (!irq_flag) begin
              if (leaving) begin
                state <= TWS_IGNORE;                                          // [R8] [R9]
              end else begin
                shreg   <= data_reg;
                last    <= ~ack_en;                                           // [R13]
                sda_drv <= ~data_reg[7];                                      // [R21]
                cnt     <= 4'h1;
                state   <= TWS_DATA;
              end
            end
          end
          TWS_DATA: begin
            if (ev.scl_fall) begin
              if (cnt == `TWS_BITS_PER_BYTE) begin
                sda_drv <= 1'b0;
                state   <= TWS_DACK;
              end else begin
                sda_drv <= ~shreg[6];                                         // [R21]
                shreg   <= {shreg[6:0], 1'b0};
                cnt     <= cnt + 4'h1;
              end
            end
          end
          TWS_DACK: begin
            if (ev.scl_rise) acked <= ~lines.sda;
            if (ev.scl_fall) begin
              leaving <= ~acked | last;
              state   <= TWS_HOLD;
            end
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Pin drive: open drain, clock stretched while the flag is pending
  always_comb begin
    pins_out.scl_o  = 1'b0;
    pins_out.sda_o  = 1'b0;
    pins_out.sda_oe = sda_drv;
    // Held through the cycle after the flag clear; the first bit is driven on the same edge that releases SCL
    pins_out.scl_oe = (state == TWS_HOLD);                                    // [R17] [R21]
  end

  // ========================================================================
  // Checks
  status_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_flag |-> status_read[7:3] == 5'h1F) else $error("status not F8"); // [R20]
  own_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_AACK && ev.scl_fall && !arb_flag && iface_en
    |=> irq_flag && status_code == `TWS_ST_OWN_READ) else $error("A8 missing"); // [R5]
  arb_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_AACK && ev.scl_fall && arb_flag && !arb_lost && iface_en
    |=> status_code == `TWS_ST_ARB_READ) else $error("B0 missing"); // [R6]
  data_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_DACK && ev.scl_fall && acked && !last && iface_en && !ev.stop
    |=> status_code == `TWS_ST_DATA_ACK && !leaving) else $error("B8 missing"); // [R7]
  data_nack_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_DACK && ev.scl_fall && !acked && iface_en && !ev.stop
    |=> status_code == `TWS_ST_DATA_NACK && leaving) else $error("C0 missing"); // [R8]
  last_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_DACK && ev.scl_fall && acked && last && iface_en && !ev.stop
    |=> status_code == `TWS_ST_LAST_ACK ##1 leaving) else $error("C8 missing"); // [R9]
  ignore_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_IGNORE |=> !pins_out.sda_oe) else $error("drives after end"); // [R14]
  no_ack_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_ADDR && !ack_en |=> state != TWS_AACK) else $error("acked while off"); // [R15]
  hold_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_HOLD && irq_flag |-> pins_out.scl_oe) else $error("clock released"); // [R17]
  msb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_HOLD && !irq_flag && !leaving && iface_en && !ev.stop && !ev.start
    |=> pins_out.sda_oe == ~$past(data_reg[7])) else $error("MSB not first"); // [R21]
  low_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == TWS_DATA && $changed(pins_out.sda_oe) |-> !lines.scl) else $error("data moved high"); // [R21]
  wake_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake |-> state == TWS_AACK && $past(sleep_mode)) else $error("bad wake"); // [R16]

  read_start_c: cover property (@(posedge pclk) state == TWS_AACK ##[1:300] state == TWS_DATA);
  nack_end_c: cover property (@(posedge pclk) irq_set && next_code == `TWS_ST_DATA_NACK);
  last_ack_c: cover property (@(posedge pclk) irq_set && next_code == `TWS_ST_LAST_ACK);
  sleep_wake_c: cover property (@(posedge pclk) wake);

endmodule : tws_slave_tx

// ---- tb/tws_master.sv ----
// External two-wire master receiver for the slave transmitter bench.
// Assumes pull-ups on both lines; 1 on an output means the line is released.
module tws_master (
  // Resolved bus lines
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain drives
  output logic      scl_rel,
  output logic      sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Link timing: 125 ns clock, runs only inside frames
  localparam real HALF = 62.5;

  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  // One clock, entered with SCL low; waits while the slave stretches SCL
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #(HALF * 0.75);
    scl_rel = 1'b1;
    wait (scl === 1'b1);
    #(HALF);
    r = sda;
    scl_rel = 1'b0;
    #(HALF * 0.25);
  endtask : bit_io

  task automatic start_c();
    sda_rel = 1'b1;
    scl_rel = 1'b1;
    #(HALF);
    sda_rel = 1'b0;
    #(HALF);
    scl_rel = 1'b0;
    #(HALF * 0.25);
  endtask : start_c

  task automatic stop_c();
    sda_rel = 1'b0;
    #(HALF * 0.75);
    scl_rel = 1'b1;
    wait (scl === 1'b1);
    #(HALF);
    sda_rel = 1'b1;
    #(HALF);
  endtask : stop_c

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send

  // Bits taken MSB first
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask : recv
endmodule : tws_master

// ---- tb/tws_slave_tx_tb.sv ----
// Self-checking bench for the two-wire slave transmitter.
// Assumes tws_master on the far side and APB driven from pclk.
`include "tws_consts.svh"
module tws_slave_tx_tb;
  import tws_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  tws_pins_in_t  pins_in;
  tws_pins_out_t pins_out;
  logic          arb_lost;
  logic          sleep_mode;
  logic          wake;
  logic          gen_start;
  logic          scl_rel;
  logic          sda_rel;
  logic [31:0]   r;
  logic          e;
  logic [7:0]    probe [4] = '{8'hB4, 8'hB7, 8'h01, 8'hB5};
  int            mismatches = 0;
  int            num_checks = 0;
  int            wake_cnt = 0;
  int            start_cnt = 0;

  // Wired-AND of every party, pull-up when released
  assign pins_in = {scl_rel & ~pins_out.scl_oe, sda_rel & ~pins_out.sda_oe};

  tws_slave_tx #(.ADDR_W(8)) i_tws_slave_tx (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_out(pins_out), .arb_lost(arb_lost),
    .sleep_mode(sleep_mode), .wake(wake), .gen_start(gen_start)
  );

  tws_master i_tws_master (.scl(pins_in.scl), .sda(pins_in.sda),
                           .scl_rel(scl_rel), .sda_rel(sda_rel));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (gen_start === 1'b1) start_cnt <= start_cnt + 1;
  end

  // ==========================================================================
  // Checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  // ==========================================================================
  // APB master
  task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_d, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_n;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_d = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, {24'h0, d}, x, y);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic y;
    apb(1'b0, a, 32'h0, x, y);
  endtask : rd

  // ==========================================================================
  // Software side: wait for the flag, check status, answer
  task automatic svc(input logic [7:0] code, input logic ld, input logic [7:0] d,
                     input logic [7:0] ctl);
    logic [31:0] x;
    int          n;
    n = 0;
    do begin
      rd(`TWS_OFF_CONTROL, x);
      n++;
    end while (x[`TWS_CTL_IRQ_FLAG] !== 1'b1 && n < 4000);
    check("irq_flag", x[`TWS_CTL_IRQ_FLAG], 1'b1);
    rd(`TWS_OFF_STATUS, x);
    check("status", x, {24'h0, code});
    if (ld) begin
      check("scl_hold", pins_out.scl_oe, 1'b1);
      wr(`TWS_OFF_DATA, d);
    end
    wr(`TWS_OFF_CONTROL, ctl);
  endtask : svc

  task automatic m_addr(input logic [7:0] a, input logic exp);
    logic ack;
    i_tws_master.start_c();
    i_tws_master.send(a, ack);
    check("addr_ack", ack, exp);
  endtask : m_addr

  task automatic m_byte(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    i_tws_master.recv(ack, d);
    check("rx_byte", d, exp);
  endtask : m_byte

  task automatic rd_one(input logic [7:0] a, input logic [7:0] code, input logic [7:0] d,
                        input logic [7:0] ctl);
    fork
      begin
        m_addr(a, 1'b1);
        m_byte(1'b0, d);
        i_tws_master.stop_c();
      end
      begin
        svc(code, 1'b1, d, 8'hC4);
        svc(`TWS_ST_DATA_NACK, 1'b0, 8'h00, ctl);
      end
    join
  endtask : rd_one

  // ==========================================================================
  // Tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    arb_lost   = 1'b0;
    sleep_mode = 1'b0;
    presetn    = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TWS_OFF_CONTROL, r);
    check("ctl_reset", r, {24'h0, `TWS_RST_CONTROL});
    rd(`TWS_OFF_STATUS, r);
    check("status_idle", r, {24'h0, `TWS_ST_NO_INFO});
    rd(`TWS_OFF_DATA, r);
    check("data_reset", r, {24'h0, `TWS_RST_DATA});
    rd(`TWS_OFF_OWN_ADDR, r);
    check("own_reset", r, {24'h0, `TWS_RST_OWN_ADDR});
    apb(1'b0, 8'h10, 32'h0, r, e);
    check("unmapped_err", e, 1'b1);
    $display("test reset_values done");
    wr(`TWS_OFF_OWN_ADDR, 8'hB4);
    wr(`TWS_OFF_CONTROL, 8'h44);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(`TWS_OFF_CONTROL, 8'h04);
      m_addr(probe[i], 1'b0);
      i_tws_master.stop_c();
    end
    rd(`TWS_OFF_STATUS, r);
    check("status_quiet", r, {24'h0, `TWS_ST_NO_INFO});
    wr(`TWS_OFF_CONTROL, 8'h44);
    $display("test refused_addresses done");
    fork
      begin
        m_addr(8'hB5, 1'b1);
        m_byte(1'b1, 8'hA5);
        m_byte(1'b1, 8'h3C);
        m_byte(1'b1, 8'hFF);
        i_tws_master.stop_c();
      end
      begin
        svc(`TWS_ST_OWN_READ, 1'b1, 8'hA5, 8'hC4);
        svc(`TWS_ST_DATA_ACK, 1'b1, 8'h3C, 8'h84);
        svc(`TWS_ST_LAST_ACK, 1'b0, 8'h00, 8'hC4);
      end
    join
    rd(`TWS_OFF_STATUS, r);
    check("status_after", r, {24'h0, `TWS_ST_NO_INFO});
    $display("test multi_byte_read done");
    @(posedge pclk);
    arb_lost   <= 1'b1;
    sleep_mode <= 1'b1;
    @(posedge pclk);
    arb_lost <= 1'b0;
    rd_one(8'hB5, `TWS_ST_ARB_READ, 8'h81, 8'hE4);
    sleep_mode <= 1'b0;
    repeat (20) @(posedge pclk);
    check("wake_pulses", wake_cnt, 1);
    check("start_pulses", start_cnt, 1);
    rd(`TWS_OFF_CONTROL, r);
    check("start_cleared", r[`TWS_CTL_START_REQ], 1'b0);
    $display("test arb_sleep_start done");
    wr(`TWS_OFF_OWN_ADDR, 8'hB5);
    rd_one(8'h01, `TWS_ST_OWN_READ, 8'h00, 8'hC4);
    $display("test general_call done");
    close_out();
  end
endmodule : tws_slave_tx_tb
